// *** phase_step_checker.sv ***
/* Assertions on the phase-step link.
 * Assumes the tb feeds the link signals and reset. */
`timescale 1ns/1ns
module phase_step_checker (
	// Link, with reset and clock enable
	input wire logic       scan_clk,
	input wire logic       rstn,
	input wire logic       clk_en,
	input wire logic       step_req,
	input wire logic       shift_up,
	input wire logic [2:0] counter_sel,
	input wire logic       step_complete
);
	default clocking cb @(posedge scan_clk); endclocking
	// Frozen cycles stretch every timing, so checks are disabled during them
	default disable iff (!rstn || !clk_en);
	// ====
	// PLL end
	sequence s_arm; step_complete [*2]; endsequence
	sequence s_busy; !step_complete [*3] ##1 step_complete; endsequence
	property p_walk; $rose(step_req) |-> s_arm ##1 s_busy; endproperty
	a_walk: assert property (p_walk) else $error("bad walk");
	property p_fall; $fell(step_complete) |-> $past(step_req, 2); endproperty
	a_fall: assert property (p_fall) else $error("bad fall");
	property p_quiet; !step_req && step_complete |=> step_complete; endproperty
	a_quiet: assert property (p_quiet) else $error("bad quiet");
	// ====
	// Controller end
	property p_req2; $rose(step_req) |=> step_req; endproperty
	a_req2: assert property (p_req2) else $error("short req");
	property p_rel; $fell(step_req) |-> !$past(step_complete); endproperty
	a_rel: assert property (p_rel) else $error("early drop");
	property p_hold; step_req && $past(step_req) |-> $stable({shift_up, counter_sel}); endproperty
	a_hold: assert property (p_hold) else $error("sel moved");
	property p_gap; $fell(step_req) |=> !step_req; endproperty
	a_gap: assert property (p_gap) else $error("no gap");
	property p_rearm; $rose(step_req) |-> $past(step_complete); endproperty
	a_rearm: assert property (p_rearm) else $error("not rearmed");
endmodule

// *** phase_step_ctrl.sv ***
/*
 * Fabric controller end: runs one phase step per user request.
 * Assumes the PLL end shares core_clk as scan clock.
 */
`timescale 1ns/1ns
`include "phase_step_regs.svh"

module phase_step_ctrl
	import phase_step_pkg::*;
(
	// Clock and control
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       clk_en,
	// Link
	phase_step_if.ctrl      link,
	// User side
	input  wire logic       go,
	input  wire logic       go_delay,
	input  wire logic [2:0] go_sel,
	output      logic       ready
);

	typedef enum logic [1:0] {
		C_IDLE,
		C_HOLD,
		C_WAITLOW,
		C_WAITHIGH
	} cstate_t;

	typedef struct packed {
		cstate_t    st;
		logic [1:0] hold;
		logic       req;
		logic       dir;
		logic [2:0] sel;
		logic       done_q;
		logic       rdy;
	} cstate_s_t;

	cstate_s_t s_r;
	cstate_s_t s_nxt;

	always_comb begin
		s_nxt        = s_r;
		s_nxt.done_q = link.step_complete;
		case (s_r.st)
			C_IDLE: begin
				// Idle also gives the required gap between pulses
				if (go && s_r.done_q) begin
					s_nxt.dir  = go_delay;
					s_nxt.sel  = go_sel;
					s_nxt.req  = 1'b1;
					s_nxt.hold = `STEP_HOLD_CYC;
					s_nxt.st   = C_HOLD;
				end
			end
			C_HOLD: begin
				if (s_r.hold > `HOLD_ONE)
					s_nxt.hold = s_r.hold - `HOLD_ONE;
				else
					s_nxt.st = C_WAITLOW;
			end
			C_WAITLOW: begin
				if (!s_r.done_q) begin
					s_nxt.req = 1'b0;
					s_nxt.st  = C_WAITHIGH;
				end
			end
			C_WAITHIGH: begin
				if (s_r.done_q)
					s_nxt.st = C_IDLE;
			end
			default: s_nxt.st = C_IDLE;
		endcase
		// Registered so the user side sees a flop, not a gate
		s_nxt.rdy = (s_nxt.st == C_IDLE) & s_nxt.done_q;
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_r        <= '0;
			s_r.done_q <= 1'b1;
			s_r.rdy    <= 1'b1;
			s_r.st     <= C_IDLE;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign link.step_req    = s_r.req;
	assign link.shift_up    = s_r.dir;
	assign link.counter_sel = s_r.sel;
	assign ready            = s_r.rdy;

endmodule

// *** phase_step_if.sv ***
/*
 * Phase-step link between the fabric controller and the PLL end.
 * Assumes both ends run on the scan clock.
 */
`timescale 1ns/1ns

interface phase_step_if;
	logic       scan_clk;
	logic       step_req;
	logic       shift_up;
	logic [2:0] counter_sel;
	logic       step_complete;

	modport pll (
		input  scan_clk,
		input  step_req,
		input  shift_up,
		input  counter_sel,
		output step_complete
	);

	modport ctrl (
		output step_req,
		output shift_up,
		output counter_sel,
		input  step_complete
	);
endinterface

// *** phase_step_pkg.sv ***
/*
 * Types shared by both ends of the phase-step handshake.
 * Assumes phase_step_regs.svh is on the include path.
 */
`include "phase_step_regs.svh"

package phase_step_pkg;

	typedef logic [`PHASE_W-1:0] phase_t;

	typedef enum logic {
		DIR_ADVANCE,
		DIR_DELAY
	} dir_t;

endpackage

// *** phase_step_regs.svh ***
/*
 * Constants for the phase-step handshake: counter selection codes,
 * phase accumulator width and timing counts.
 * Assumes inclusion by the package and both ends of the link.
 */
`ifndef PHASE_STEP_REGS_SVH
`define PHASE_STEP_REGS_SVH

// ============================================================
// Counter selection codes
`define SEL_ALL      3'h0
`define SEL_FEEDBACK 3'h1
`define SEL_POST0    3'h2
`define SEL_POST1    3'h3
`define SEL_POST2    3'h4
`define SEL_POST3    3'h5
`define SEL_POST4    3'h6

// ============================================================
// Counter masks, bit 0 feedback, bits 1 to 5 post dividers
`define MASK_NONE     6'h00
`define MASK_FEEDBACK 6'h01
`define MASK_POST0    6'h02
`define MASK_POST1    6'h04
`define MASK_POST2    6'h08
`define MASK_POST3    6'h10
`define MASK_POST4    6'h20
`define MASK_ALL_POST 6'h3e

// ============================================================
// Phase and timing
`define PHASE_W        16
`define PHASE_ONE      16'h0001
`define PHASE_RESET    16'h0000
`define STEP_HOLD_CYC  2'h2
`define HOLD_ONE       2'h1
`define SHIFT_BUSY_CYC 3'h3
`define CNT_ZERO       3'h0
`define CNT_ONE        3'h1
`define NUM_CNT        6

`endif

// *** pll_phase_step.sv ***
/*
 * PLL end of the phase-step handshake: falling-edge request sampler,
 * counter selection decode, per-counter phase accumulators counted in
 * eighths of a VCO period, and the completion flag.
 * Assumes core_clk also serves as the link's scan clock, that the
 * controller keeps the request high until it sees the completion flag
 * low, and that clk_en low freezes both ends together.
 */
`timescale 1ns/1ns
`include "phase_step_regs.svh"

module pll_phase_step
	import phase_step_pkg::*;
(
	// Clock and control
	input  wire logic                  core_clk,
	input  wire logic                  rstn,
	input  wire logic                  clk_en,
	// Link
	phase_step_if.pll                  link,
	// Phase state in eighths of a VCO period
	output      logic [`PHASE_W-1:0]   feedback_phase,
	output      logic [`PHASE_W-1:0]   post_divider_0,
	output      logic [`PHASE_W-1:0]   post_divider_1,
	output      logic [`PHASE_W-1:0]   post_divider_2,
	output      logic [`PHASE_W-1:0]   post_divider_3,
	output      logic [`PHASE_W-1:0]   post_divider_4,
	output      logic                  shift_busy
);

	// ============================================================
	// Falling-edge sampler
	// Only state outside the struct, as it lives on the other edge
	// Clock enable freezes this flop as well
	logic neg_req_r;

	always_ff @(negedge core_clk) begin
		if (!rstn) begin
			neg_req_r <= 1'b0;
		end else if (clk_en) begin
			neg_req_r <= link.step_req;
		end
	end

	// ============================================================
	// State
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_SHIFT,
		ST_REARM
	} pstate_t;

	typedef struct packed {
		pstate_t                 st;
		logic [2:0]              cnt;
		logic                    dir;
		logic [2:0]              sel;
		logic                    done;
		logic                    busy;
		phase_t [`NUM_CNT-1:0]   ph;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// ============================================================
	// Counter selection decode
	// Bit 0 is the feedback counter, bits 1 to 5 the post dividers
	// Decoded once so the accumulator loop is a plain mask test
	logic [`NUM_CNT-1:0] sel_mask;

	always_comb begin
		sel_mask = `MASK_NONE;
		case (s_r.sel)
			`SEL_ALL: begin
				sel_mask = `MASK_ALL_POST;
			end

			`SEL_FEEDBACK: begin
				sel_mask = `MASK_FEEDBACK;
			end

			`SEL_POST0: begin
				sel_mask = `MASK_POST0;
			end

			`SEL_POST1: begin
				sel_mask = `MASK_POST1;
			end

			`SEL_POST2: begin
				sel_mask = `MASK_POST2;
			end

			`SEL_POST3: begin
				sel_mask = `MASK_POST3;
			end

			`SEL_POST4: begin
				sel_mask = `MASK_POST4;
			end

			default: begin
				// Code seven moves nothing, yet the handshake still runs
				sel_mask = `MASK_NONE;
			end
		endcase
	end

	// ============================================================
	// Per-counter step arithmetic
	// Accumulators wrap silently; whole turns are not tracked
	phase_t stepped [`NUM_CNT];

	for (genvar g = 0; g < `NUM_CNT; g++) begin : g_step
		always_comb begin
			stepped[g] = s_r.ph[g];
			case (dir_t'(s_r.dir))
				DIR_DELAY: begin
					stepped[g] = s_r.ph[g] + `PHASE_ONE;
				end

				DIR_ADVANCE: begin
					stepped[g] = s_r.ph[g] - `PHASE_ONE;
				end

				default: begin
					stepped[g] = s_r.ph[g];
				end
			endcase
		end
	end

	// ============================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			ST_IDLE: begin
				// Sampled at negedge, so next rise is the first after latching
				if (neg_req_r) begin
					s_nxt.st = ST_WAIT;
				end
			end

			ST_WAIT: begin
				// Direction and selection taken here, not with the request
				s_nxt.dir  = link.shift_up;
				s_nxt.sel  = link.counter_sel;
				s_nxt.done = 1'b0;
				s_nxt.busy = 1'b1;
				s_nxt.cnt  = `SHIFT_BUSY_CYC;
				s_nxt.st   = ST_SHIFT;
			end

			ST_SHIFT: begin
				if (s_r.cnt == `CNT_ONE) begin
					// One step per pulse, applied once at the end
					for (int i = 0; i < `NUM_CNT; i++) begin
						if (sel_mask[i]) begin
							s_nxt.ph[i] = stepped[i];
						end
					end
					s_nxt.done = 1'b1;
					s_nxt.busy = 1'b0;
					s_nxt.st   = ST_REARM;
				end
				s_nxt.cnt = s_r.cnt - `CNT_ONE;
			end

			ST_REARM: begin
				// A request still high is the same pulse and must not step again
				if (!neg_req_r) begin
					s_nxt.st = ST_IDLE;
				end
			end

			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
	end

	// ============================================================
	// State register
	// Reset clears every accumulator; the controller restarts from zero
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_r      <= '0;
			s_r.done <= 1'b1;
			s_r.st   <= ST_IDLE;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// ============================================================
	// Outputs, each a bare register bit
	// Busy has its own bit so it leaves a flop, not an inverter
	assign link.step_complete = s_r.done;
	assign shift_busy         = s_r.busy;
	assign feedback_phase     = s_r.ph[0];
	assign post_divider_0     = s_r.ph[1];
	assign post_divider_1     = s_r.ph[2];
	assign post_divider_2     = s_r.ph[3];
	assign post_divider_3     = s_r.ph[4];
	assign post_divider_4     = s_r.ph[5];

endmodule

// *** tb.sv ***
/* Testbench joining both ends of the phase-step link.
 * Assumes package, header and interface compile first. */
`timescale 1ns/1ns
module tb;
	import phase_step_pkg::*;
	logic       core_clk, rstn, clk_en, go, go_delay, ready, busy;
	logic [2:0] go_sel;
	phase_t     ph [6];
	phase_t     exp_ph [6];
	int         n_fail, n_tests, i;
	phase_step_if link ();
	assign link.scan_clk = core_clk;
	pll_phase_step u_pll_phase_step (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
		.link(link), .feedback_phase(ph[0]), .post_divider_0(ph[1]), .post_divider_1(ph[2]),
		.post_divider_2(ph[3]), .post_divider_3(ph[4]), .post_divider_4(ph[5]),
		.shift_busy(busy));
	phase_step_ctrl u_phase_step_ctrl (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
		.link(link), .go(go), .go_delay(go_delay), .go_sel(go_sel), .ready(ready));
	phase_step_checker u_phase_step_checker (.scan_clk(link.scan_clk), .rstn(rstn),
		.clk_en(clk_en),
		.step_req(link.step_req), .shift_up(link.shift_up),
		.counter_sel(link.counter_sel), .step_complete(link.step_complete));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// ====
	// Helpers
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, want, seen);
		end
	endtask
	task give_verdict;
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task cmp_all;
		for (int k = 0; k < 6; k++) chk($sformatf("phase%0d", k), ph[k], exp_ph[k]);
	endtask
	// Bounded wait, a hang ends the run
	task wait_done(input logic v);
		for (i = 0; i < 40 && link.step_complete !== v; i++) @(posedge core_clk) #1;
		if (link.step_complete !== v) begin
			n_fail++;
			give_verdict();
		end
	endtask
	task wait_ready;
		for (i = 0; i < 40 && ready !== 1'b1; i++) @(posedge core_clk) #1;
		if (ready !== 1'b1) begin
			n_fail++;
			give_verdict();
		end
	endtask
	task step(input logic d, input logic [2:0] s);
		phase_t inc;
		inc = d ? 16'h0001 : 16'hffff;
		go = 1'b1;
		go_delay = d;
		go_sel = s;
		wait_ready();
		@(posedge core_clk) #1;
		go = 1'b0;
		chk("ready", {15'h0000, ready}, 16'h0000);
		wait_done(1'b0);
		chk("busy", {15'h0000, busy}, 16'h0001);
		wait_done(1'b1);
		if (s == 3'h0)
			for (int k = 1; k < 6; k++) exp_ph[k] += inc;
		else if (s == 3'h1)
			exp_ph[0] += inc;
		else if (s != 3'h7)
			exp_ph[s - 3'h1] += inc;
		cmp_all();
	endtask
	// ====
	// Scenarios
	task t_all;
		step(1'b1, 3'h0);
		step(1'b0, 3'h0);
		$display("t_all finished");
	endtask
	task t_codes;
		for (int k = 0; k < 8; k++) step(1'b1, k[2:0]);
		$display("t_codes finished");
	endtask
	// Back to back, only the one C_IDLE cycle between steps
	task t_accum;
		repeat (5) step(1'b0, 3'h1);
		$display("t_accum finished");
	endtask
	// Clock enable low mid-shift stretches busy, one step still lands
	task t_freeze;
		go = 1'b1;
		go_delay = 1'b1;
		go_sel = 3'h2;
		wait_ready();
		@(posedge core_clk) #1;
		go = 1'b0;
		wait_done(1'b0);
		clk_en = 1'b0;
		repeat (10) @(posedge core_clk) #1;
		chk("frozen done", {15'h0000, link.step_complete}, 16'h0000);
		cmp_all();
		clk_en = 1'b1;
		wait_done(1'b1);
		exp_ph[1] += 16'h0001;
		cmp_all();
		$display("t_freeze finished");
	endtask
	// Idle controller leaves the link inputs constant, nothing may move
	task t_idle;
		repeat (20) @(posedge core_clk) #1;
		chk("idle req", {15'h0000, link.step_req}, 16'h0000);
		chk("idle done", {15'h0000, link.step_complete}, 16'h0001);
		cmp_all();
		$display("t_idle finished");
	endtask
	// Mid-run reset clears every accumulator and rearms both ends
	task t_reset;
		rstn = 1'b0;
		repeat (2) @(posedge core_clk) #1;
		rstn = 1'b1;
		exp_ph = '{default: 16'h0000};
		chk("reset done", {15'h0000, link.step_complete}, 16'h0001);
		chk("reset ready", {15'h0000, ready}, 16'h0001);
		cmp_all();
		step(1'b0, 3'h6);
		$display("t_reset finished");
	endtask
	initial begin
		rstn = 1'b0;
		clk_en = 1'b1;
		go = 1'b0;
		go_delay = 1'b0;
		go_sel = 3'h0;
		n_fail = 0;
		n_tests = 0;
		exp_ph = '{default: 16'h0000};
		repeat (16) @(posedge core_clk);
		#1 rstn = 1'b1;
		chk("done", {15'h0000, link.step_complete}, 16'h0001);
		cmp_all();
		t_all();
		t_codes();
		t_accum();
		t_freeze();
		t_idle();
		t_reset();
		give_verdict();
	end
endmodule
